// file: rtl/dram_init_seq.sv
`timescale 1ns/1ps
`include "dram_init_map.svh"
module dram_init_seq #(
  parameter int unsigned CKE_AFTER_RESET_CYCLES =
    (`CKE_AFTER_RESET_WAIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic                      reset_n_pin,
  input  wire logic                      cke_pin,
  input  wire logic                      cmd_valid,
  input  wire dram_init_pkg::cmd_t       cmd,
  input  wire logic [5:0]                ca_pattern,
  input  wire logic                      wrlev_sample,
  input  wire logic [7:0]                zq_result,
  output logic [15:0]                    dq_out,
  output logic                           dq_oe,
  output dram_init_pkg::cal_codes_t      cal_codes,
  output dram_init_pkg::phase_t          phase,
  output logic                           ready_normal
);
  import dram_init_pkg::*;

  localparam logic [16:0] MODE_WAIT_CYC =
    17'((`FIRST_MODE_WAIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS);
  localparam logic [16:0] CAL_CYC =
    17'((`CALIBRATION_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS);
  localparam int unsigned QUIET_NS_CYC =
    (`LATCH_QUIET_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
  localparam logic [16:0] QUIET_CYC =
    17'((QUIET_NS_CYC > `LATCH_QUIET_CK) ? QUIET_NS_CYC : `LATCH_QUIET_CK);
  localparam logic [16:0] CKE_WAIT_CYC = 17'(CKE_AFTER_RESET_CYCLES);
  localparam logic [16:0] CNT_MAX = 17'h1ffff;

  function automatic logic [7:0] mr_default(input logic [3:0] idx);
    case (idx)
      `MR_IDX_WRREC:    mr_default = `MR_WRREC_RESET;
      `MR_IDX_LATENCY:  mr_default = `MR_LATENCY_RESET;
      `MR_IDX_INVERT:   mr_default = `MR_INVERT_RESET;
      `MR_IDX_TERM:     mr_default = `MR_TERM_RESET;
      `MR_IDX_CA_REF:   mr_default = `MR_CA_REF_RESET;
      `MR_IDX_SETPOINT: mr_default = `MR_SETPOINT_RESET;
      `MR_IDX_DQ_REF:   mr_default = `MR_DQ_REF_RESET;
      default:          mr_default = `MR_OTHER_RESET;
    endcase
  endfunction

  // Pin synchronisers; only stages 2 and 3 are compared
  logic [2:0]  rstn_sync_r;
  logic [2:0]  cke_sync_r;
  logic        rstn_s_r;
  logic        cke_s_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      rstn_sync_r <= 3'h0;
      cke_sync_r  <= 3'h0;
      rstn_s_r    <= 1'b0;
      cke_s_r     <= 1'b0;
    end else begin
      rstn_sync_r <= {rstn_sync_r[1:0], reset_n_pin};
      cke_sync_r  <= {cke_sync_r[1:0], cke_pin};
      if (rstn_sync_r[1] == rstn_sync_r[2]) rstn_s_r <= rstn_sync_r[2];
      if (cke_sync_r[1] == cke_sync_r[2]) cke_s_r <= cke_sync_r[2];
    end
  end

  wire dev_reset = rst | ~rstn_s_r;
  logic cke_sync_hold_r;
  wire cke_rise  = cke_s_r & ~cke_sync_hold_r;
  always_ff @(posedge clock) begin
    if (dev_reset) cke_sync_hold_r <= 1'b0;
    else cke_sync_hold_r <= cke_s_r;
  end

  logic [7:0]  mr_r [`MR_COUNT];
  phase_t      phase_r;
  phase_t      phase_nxt;
  logic [16:0] reset_cnt_r;
  logic [16:0] mode_cnt_r;
  logic [16:0] cal_cnt_r;
  logic [16:0] quiet_cnt_r;
  logic        cal_busy_r;
  logic        cal_done_r;
  logic        latched_r;
  logic        cbt_done_r;
  logic        wrlev_done_r;
  logic        dq_done_r;
  logic [15:0] fifo_r [4];
  logic [1:0]  fifo_wp_r;
  logic [1:0]  fifo_rp_r;
  logic [31:0] ctrl_r;
  logic [`ERR_WIDTH-1:0] err_r;
  logic [`ERR_WIDTH-1:0] err_set;
  logic [15:0] refused_r;
  logic [3:0]  mr_sel_r;

  wire cmd_go      = cmd_valid & cke_s_r & (phase_r != PH_RESET);
  wire is_mrw      = cmd_go & (cmd.kind == CMD_MRW);
  wire is_mrr      = cmd_go & (cmd.kind == CMD_MRR);
  wire is_mpc      = cmd_go & (cmd.kind == CMD_MPC);
  wire is_zq_start = cmd_go & (cmd.kind == CMD_ZQ_START);
  wire is_zq_latch = cmd_go & (cmd.kind == CMD_ZQ_LATCH);
  wire is_array    = cmd_go & (cmd.kind == CMD_ARRAY);
  wire mr_hit      = (cmd.addr < 6'(`MR_COUNT));
  wire [3:0] mr_idx = cmd.addr[3:0];
  wire mr2_wrlev   = is_mrw & mr_hit & (mr_idx == `MR_IDX_LATENCY);
  wire mr13_write  = is_mrw & mr_hit & (mr_idx == `MR_IDX_SETPOINT);
  wire bypass      = ctrl_r[`CTRL_BYPASS_BIT];
  wire trained     = bypass | (cbt_done_r & wrlev_done_r & dq_done_r);
  wire refuse      = is_array & (phase_r != PH_NORMAL);

  // Device-observed timing breaches; the device still obeys the command
  always_comb begin
    err_set = '0;
    err_set[`ERR_EARLY_MODE]  = (is_mrw | is_mrr) & (mode_cnt_r < MODE_WAIT_CYC);
    err_set[`ERR_EARLY_LATCH] = is_zq_latch & (cal_cnt_r < CAL_CYC);
    err_set[`ERR_QUIET]       = cmd_go & latched_r & (quiet_cnt_r < QUIET_CYC);
    err_set[`ERR_EARLY_CKE]   = cke_rise & (reset_cnt_r < CKE_WAIT_CYC);
  end

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_RESET:    phase_nxt = PH_CKE_WAIT;
      PH_CKE_WAIT: if (cke_s_r) phase_nxt = PH_BOOT;
      PH_BOOT: begin
        if (mr13_write & cmd.op[`MR_CBT_BIT]) phase_nxt = PH_CBT;
        else if (mr2_wrlev & cmd.op[`MR_WRLEV_BIT]) phase_nxt = PH_WRLEV;
        else if (is_mpc) phase_nxt = PH_DQ_TRAIN;
        else if (trained) phase_nxt = PH_NORMAL;
      end
      PH_CBT:      if (mr13_write & ~cmd.op[`MR_CBT_BIT]) phase_nxt = PH_BOOT;
      // Leveling left by clearing bit 7
      PH_WRLEV:    if (mr2_wrlev & ~cmd.op[`MR_WRLEV_BIT]) phase_nxt = PH_BOOT;
      PH_DQ_TRAIN: if (trained) phase_nxt = PH_NORMAL;
      PH_NORMAL:   phase_nxt = PH_NORMAL;
      default:     phase_nxt = PH_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (dev_reset) begin
      phase_r      <= PH_RESET;
      cbt_done_r   <= 1'b0;
      wrlev_done_r <= 1'b0;
      dq_done_r    <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      if (phase_r == PH_CBT && phase_nxt == PH_BOOT) cbt_done_r <= 1'b1;
      if (phase_r == PH_WRLEV && phase_nxt == PH_BOOT) wrlev_done_r <= 1'b1;
      if (is_mpc && cmd.op == `MPC_FIFO_READ) dq_done_r <= 1'b1;
    end
  end

  // Saturating counters; a narrow counter would wrap and make a late step look early
  always_ff @(posedge clock) begin
    if (dev_reset) begin
      reset_cnt_r <= '0;
      mode_cnt_r  <= '0;
      cal_cnt_r   <= '0;
      quiet_cnt_r <= '0;
    end else begin
      if (!cke_s_r && reset_cnt_r != CNT_MAX) reset_cnt_r <= reset_cnt_r + 17'h1;
      if (!cke_s_r) mode_cnt_r <= '0;
      else if (mode_cnt_r != CNT_MAX) mode_cnt_r <= mode_cnt_r + 17'h1;
      if (is_zq_start) cal_cnt_r <= '0;
      else if (cal_cnt_r != CNT_MAX) cal_cnt_r <= cal_cnt_r + 17'h1;
      if (is_zq_latch) quiet_cnt_r <= '0;
      else if (quiet_cnt_r != CNT_MAX) quiet_cnt_r <= quiet_cnt_r + 17'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (dev_reset) begin
      for (int i = 0; i < `MR_COUNT; i++) mr_r[i] <= mr_default(4'(i));
    end else if (is_mrw && mr_hit) begin
      mr_r[mr_idx] <= cmd.op;
    end
  end

  always_ff @(posedge clock) begin
    if (dev_reset) begin
      cal_busy_r <= 1'b0;
      cal_done_r <= 1'b0;
      latched_r  <= 1'b0;
      cal_codes  <= '0;
    end else begin
      if (is_zq_start) begin
        cal_busy_r <= 1'b1;
        cal_done_r <= 1'b0;
      end else if (cal_busy_r && cal_cnt_r >= CAL_CYC) begin
        cal_busy_r <= 1'b0;
        cal_done_r <= 1'b1;
      end
      if (is_zq_latch) begin
        latched_r       <= 1'b1;
        cal_codes.drive <= zq_result;
        cal_codes.term  <= zq_result;
      end
    end
  end

  // Training data held apart from the array
  always_ff @(posedge clock) begin
    if (dev_reset) begin
      fifo_wp_r <= 2'h0;
      fifo_rp_r <= 2'h0;
    end else if (is_mpc && cmd.op == `MPC_FIFO_WRITE) begin
      fifo_r[fifo_wp_r] <= {ca_pattern, ca_pattern[5:2], cmd.addr};
      fifo_wp_r         <= fifo_wp_r + 2'h1;
    end else if (is_mpc && cmd.op == `MPC_FIFO_READ) begin
      fifo_rp_r <= fifo_rp_r + 2'h1;
    end
  end

  // Command pattern, leveling sample, calibration pattern, FIFO entry or mode register returned on data bus
  wire [15:0] dq_nxt =
    (phase_r == PH_CBT)                        ? {10'h0, ca_pattern} :
    (phase_r == PH_WRLEV)                      ? {16{wrlev_sample}} :
    (is_mpc && cmd.op == `MPC_READ_CAL)        ? `READ_CAL_PATTERN :
    (is_mpc && cmd.op == `MPC_FIFO_READ)       ? fifo_r[fifo_rp_r] :
    (is_mrr && mr_hit)                         ? {8'h0, mr_r[mr_idx]} : 16'h0;
  wire drive_nxt = (phase_r == PH_CBT) | (phase_r == PH_WRLEV) |
                   (is_mpc && (cmd.op == `MPC_READ_CAL || cmd.op == `MPC_FIFO_READ)) |
                   is_mrr;

  // Released while reset or clock enable low
  always_ff @(posedge clock) begin
    if (dev_reset || !cke_s_r) begin
      dq_out       <= 16'h0;
      dq_oe        <= 1'b0;
      ready_normal <= 1'b0;
      phase        <= PH_RESET;
    end else begin
      dq_out       <= dq_nxt;
      dq_oe        <= drive_nxt;
      ready_normal <= (phase_nxt == PH_NORMAL);
      phase        <= phase_nxt;
    end
  end

  // AHB-Lite slave, zero wait states
  wire        ap_take  = hsel & htrans[1] & hready;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  wire [7:0]  ap_addr  = haddr[7:0];
  wire        ap_known = (haddr[31:8] == 24'h0) & (ap_addr[1:0] == 2'h0);
  wire [31:0] status_word = {16'h0, 2'h0, trained, latched_r, cal_done_r, cal_busy_r,
                             dq_done_r, wrlev_done_r, cbt_done_r, rstn_s_r, cke_s_r,
                             2'h0, phase_r};
  wire [31:0] rd_mux =
    !ap_known                   ? 32'h0 :
    (ap_addr == `REG_CTRL)      ? ctrl_r :
    (ap_addr == `REG_STATUS)    ? status_word :
    (ap_addr == `REG_ERROR)     ? {28'h0, err_r} :
    (ap_addr == `REG_MR_SELECT) ? {28'h0, mr_sel_r} :
    (ap_addr == `REG_MR_DATA)   ? {24'h0, mr_r[mr_sel_r]} :
    (ap_addr == `REG_REFUSED)   ? {16'h0, refused_r} : 32'h0;
  wire wr_ctrl  = wr_pend_r & (wr_addr_r == `REG_CTRL);
  wire wr_err   = wr_pend_r & (wr_addr_r == `REG_ERROR);
  wire wr_sel   = wr_pend_r & (wr_addr_r == `REG_MR_SELECT);
  wire [`ERR_WIDTH-1:0] err_clr = wr_err ? hwdata[`ERR_WIDTH-1:0] : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      ctrl_r    <= `CTRL_RESET;
      mr_sel_r  <= 4'h0;
    end else begin
      wr_pend_r <= ap_take & hwrite & ap_known;
      wr_addr_r <= ap_addr;
      if (ap_take && !hwrite) hrdata <= rd_mux;
      if (wr_ctrl) ctrl_r <= hwdata;
      if (wr_sel) mr_sel_r <= hwdata[3:0];
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      err_r     <= '0;
      refused_r <= 16'h0;
    end else begin
      err_r <= (err_r & ~err_clr) | err_set;
      if (refuse && refused_r != 16'hffff) refused_r <= refused_r + 16'h1;
    end
  end

endmodule

// file: rtl/dram_init_map.svh
`ifndef DRAM_INIT_MAP_SVH
`define DRAM_INIT_MAP_SVH

// Bus register byte offsets
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_ERROR         8'h08
`define REG_MR_SELECT     8'h0c
`define REG_MR_DATA       8'h10
`define REG_REFUSED       8'h14

// Control fields
`define CTRL_BYPASS_BIT   0
`define CTRL_RESET        32'h0000_0000

// Error flag positions
`define ERR_EARLY_MODE    0
`define ERR_EARLY_LATCH   1
`define ERR_QUIET         2
`define ERR_EARLY_CKE     3
`define ERR_WIDTH         4

// Mode register indices and fields
`define MR_COUNT          16
`define MR_IDX_ZERO       4'h0
`define MR_IDX_WRREC      4'h1
`define MR_IDX_LATENCY    4'h2
`define MR_IDX_INVERT     4'h3
`define MR_IDX_TERM       4'hb
`define MR_IDX_CA_REF     4'hc
`define MR_IDX_SETPOINT   4'hd
`define MR_IDX_DQ_REF     4'he
`define MR_WRLEV_BIT      7
`define MR_CBT_BIT        0

// Mode register reset values
`define MR_WRREC_RESET    8'h00
`define MR_LATENCY_RESET  8'h00
`define MR_INVERT_RESET   8'h00
`define MR_TERM_RESET     8'h00
`define MR_CA_REF_RESET   8'h4d
`define MR_SETPOINT_RESET 8'h00
`define MR_DQ_REF_RESET   8'h4d
`define MR_OTHER_RESET    8'h00

// Multipurpose command opcodes
`define MPC_READ_CAL      8'h43
`define MPC_FIFO_WRITE    8'h47
`define MPC_FIFO_READ     8'h41
`define READ_CAL_PATTERN  16'ha55a

// Timing
`define CLOCK_PERIOD_NS         40
`define CKE_AFTER_RESET_WAIT_NS 2000000
`define FIRST_MODE_WAIT_NS      2000
`define CALIBRATION_TIME_NS     1000
`define LATCH_QUIET_NS          30
`define LATCH_QUIET_CK          8

`endif

// file: rtl/dram_init_pkg.sv
package dram_init_pkg;

  typedef enum logic [2:0] {
    PH_RESET    = 3'b000,
    PH_CKE_WAIT = 3'b001,
    PH_BOOT     = 3'b010,
    PH_CBT      = 3'b011,
    PH_WRLEV    = 3'b100,
    PH_DQ_TRAIN = 3'b101,
    PH_NORMAL   = 3'b110
  } phase_t;

  typedef enum logic [2:0] {
    CMD_MRW       = 3'b000,
    CMD_MRR       = 3'b001,
    CMD_MPC       = 3'b010,
    CMD_ZQ_START  = 3'b011,
    CMD_ZQ_LATCH  = 3'b100,
    CMD_ARRAY     = 3'b101
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t   kind;
    logic [5:0]  addr;
    logic [7:0]  op;
  } cmd_t;

  typedef struct packed {
    logic [7:0]  drive;
    logic [7:0]  term;
  } cal_codes_t;

endpackage

// file: tb/dram_init_seq_checker.sv
`timescale 1ns/1ps
module dram_init_seq_checker (
  input wire logic                       clock,
  input wire logic                       rst,
  input wire logic                       reset_n_pin,
  input wire logic                       cke_pin,
  input wire logic                       cmd_valid,
  input wire dram_init_pkg::cmd_t        cmd,
  input wire logic [5:0]                 ca_pattern,
  input wire logic                       wrlev_sample,
  input wire logic [7:0]                 zq_result,
  input wire logic [15:0]                dq_out,
  input wire logic                       dq_oe,
  input wire dram_init_pkg::cal_codes_t  cal_codes,
  input wire dram_init_pkg::phase_t      phase,
  input wire logic                       ready_normal
);
  import dram_init_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Six samples cover the pin synchroniser delay
  sequence seq_pin_low;
    !reset_n_pin [*6];
  endsequence
  sequence seq_cke_low;
    !cke_pin [*6];
  endsequence
  sequence seq_in_cbt;
    phase == PH_CBT && $past(phase) == PH_CBT;
  endsequence
  sequence seq_in_wrlev;
    phase == PH_WRLEV && $past(phase) == PH_WRLEV;
  endsequence

  chk_oe_pin_low: assert property (seq_pin_low |-> !dq_oe)
    else $error("data bus driven while reset pin low");
  chk_oe_cke_low: assert property (seq_cke_low |-> !dq_oe && phase == PH_RESET)
    else $error("data bus driven or phase kept while cke low");
  chk_ready_phase: assert property (ready_normal |-> phase == PH_NORMAL)
    else $error("ready outside normal phase");
  chk_cbt_echo: assert property (seq_in_cbt |->
      dq_oe && dq_out == {10'h000, $past(ca_pattern)})
    else $error("training echo differs from command pattern");
  chk_wrlev_level: assert property (seq_in_wrlev |-> dq_out == {16{$past(wrlev_sample)}})
    else $error("leveling output differs from sample");
  chk_wrlev_entry: assert property ((cmd_valid && cmd.kind == CMD_MRW && cmd.addr == 6'h02
      && cmd.op[7] && phase == PH_BOOT) |=> phase == PH_WRLEV)
    else $error("leveling not entered");
  chk_cbt_entry: assert property ((cmd_valid && cmd.kind == CMD_MRW && cmd.addr == 6'h0d
      && cmd.op[0] && phase == PH_BOOT) |=> phase == PH_CBT ##1 (phase == PH_CBT && dq_oe))
    else $error("command training not entered");
  chk_latch_codes: assert property ((cmd_valid && cmd.kind == CMD_ZQ_LATCH
      && phase != PH_RESET) |=> cal_codes.term == $past(zq_result))
    else $error("latched termination code wrong");
endmodule

bind dram_init_seq dram_init_seq_checker u_dram_init_seq_checker (
  .clock(clock), .rst(rst), .reset_n_pin(reset_n_pin), .cke_pin(cke_pin),
  .cmd_valid(cmd_valid), .cmd(cmd), .ca_pattern(ca_pattern), .wrlev_sample(wrlev_sample),
  .zq_result(zq_result), .dq_out(dq_out), .dq_oe(dq_oe), .cal_codes(cal_codes),
  .phase(phase), .ready_normal(ready_normal)
);

// file: tb/dram_ctrl_model.sv
`timescale 1ns/1ps
module dram_ctrl_model #(
  parameter int CKE_WAIT = 20
) (
  input  wire logic           clock,
  output logic                reset_n_pin,
  output logic                cke_pin,
  output logic                cmd_valid,
  output dram_init_pkg::cmd_t cmd,
  output logic [5:0]          ca_pattern,
  output logic                wrlev_sample,
  output logic [7:0]          zq_result
);
  import dram_init_pkg::*;
  initial begin
    reset_n_pin = 1'b0;
    cke_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    ca_pattern = 6'h00;
    wrlev_sample = 1'b0;
    zq_result = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // cke low first, then whole-cycle reset pulse
  task automatic pin_reset(input int n);
    cke_pin <= 1'b0;
    idle(1);
    reset_n_pin <= 1'b0;
    idle(n);
    reset_n_pin <= 1'b1;
  endtask
  // full wait, clock running, no command at rise
  task automatic cke_up();
    idle(CKE_WAIT + 8);
    cmd_valid <= 1'b0;
    cke_pin <= 1'b1;
    idle(56);
  endtask
  task automatic cke_down();
    cke_pin <= 1'b0;
    idle(8);
  endtask
  task automatic issue(input cmd_kind_t k, input logic [5:0] a, input logic [7:0] op);
    cmd_valid <= 1'b1;
    cmd <= {k, a, op};
    idle(1);
    cmd_valid <= 1'b0;
    // Gap cycle so back-to-back commands never re-raise the strobe at once
    idle(1);
  endtask
  task automatic set_lines(input logic [5:0] ca, input logic ws);
    ca_pattern <= ca;
    wrlev_sample <= ws;
  endtask
  // one device, 1 us wait, 8 quiet clocks
  task automatic calibrate(input logic [7:0] code);
    issue(CMD_ZQ_START, 6'h00, 8'h00);
    idle(26);
    zq_result <= code;
    issue(CMD_ZQ_LATCH, 6'h00, 8'h00);
    idle(9);
  endtask
endmodule

// file: tb/test_dram_init_seq.sv
`timescale 1ns/1ps
`include "dram_init_map.svh"
module test_dram_init_seq;
  import dram_init_pkg::*;
  localparam int CKE_CYC = 20;
  logic clock, rst, hsel, hwrite, hreadyout, hresp, dq_oe, ready_normal;
  logic reset_n_pin, cke_pin, cmd_valid, wrlev_sample;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] ca_pattern;
  logic [7:0] zq_result;
  logic [15:0] dq_out, lfsr, r;
  wire hready = hreadyout;
  cmd_t cmd;
  cal_codes_t cal_codes;
  phase_t phase;
  int err_total, compares;
  int mr [16];
  logic [15:0] fifo [$];

  dram_init_seq #(.CKE_AFTER_RESET_CYCLES(CKE_CYC)) u_dram_init_seq (.clock(clock), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .reset_n_pin(reset_n_pin), .cke_pin(cke_pin), .cmd_valid(cmd_valid), .cmd(cmd),
    .ca_pattern(ca_pattern), .wrlev_sample(wrlev_sample), .zq_result(zq_result),
    .dq_out(dq_out), .dq_oe(dq_oe), .cal_codes(cal_codes), .phase(phase),
    .ready_normal(ready_normal));
  dram_ctrl_model #(.CKE_WAIT(CKE_CYC)) u_ctrl (.clock(clock), .reset_n_pin(reset_n_pin),
    .cke_pin(cke_pin), .cmd_valid(cmd_valid), .cmd(cmd), .ca_pattern(ca_pattern),
    .wrlev_sample(wrlev_sample), .zq_result(zq_result));

  // 40 ns boot period, above the 18 ns floor
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  // Over the bus, mode registers are only visible through the select/data pair
  task automatic check_mrs();
    for (int i = 0; i < 16; i++) begin
      ahb(`REG_MR_SELECT, 1'b1, i);
      ahb(`REG_MR_DATA, 1'b0, 32'h0);
      check(rd, mr[i]);
    end
  endtask
  task automatic mr_defaults();
    mr = '{default: 0};
    mr[12] = 8'h4d;
    mr[14] = 8'h4d;
  endtask
  task automatic mrw(input int a, input logic [7:0] op);
    u_ctrl.issue(CMD_MRW, a[5:0], op);
    mr[a] = op;
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lfsr = 16'h8c25;
    mr_defaults();
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({31'h0, dq_oe}, 32'h0);
    check_mrs();
    u_ctrl.pin_reset(5000);
    u_ctrl.cke_up();
    u_ctrl.issue(CMD_MRR, 6'h0c, 8'h00);
    check({15'h0, dq_oe, dq_out}, {15'h0, 1'b1, 8'h0, mr[12][7:0]});
    r = rnd();
    mrw(1, r[7:0]);
    r = rnd();
    u_ctrl.calibrate(r[7:0]);
    check({24'h0, cal_codes.term}, {24'h0, r[7:0]});
    check({24'h0, cal_codes.drive}, {24'h0, r[7:0]});
    mrw(13, 8'h01);
    r = rnd();
    u_ctrl.set_lines(r[5:0], r[6]);
    u_ctrl.idle(3);
    check({15'h0, dq_oe, dq_out}, {15'h0, 1'b1, 10'h0, r[5:0]});
    mrw(13, 8'h00);
    mrw(2, 8'h80);
    u_ctrl.idle(3);
    check({16'h0, dq_out}, {16'h0, {16{r[6]}}});
    mrw(2, 8'h00);
    u_ctrl.issue(CMD_MPC, 6'h00, `MPC_READ_CAL);
    check({16'h0, dq_out}, 32'h0000_a55a);
    r = rnd();
    u_ctrl.set_lines(r[5:0], r[6]);
    u_ctrl.issue(CMD_MPC, 6'h15, `MPC_FIFO_WRITE);
    fifo.push_back({r[5:0], r[5:2], 6'h15});
    u_ctrl.issue(CMD_ARRAY, 6'h00, 8'h00);
    u_ctrl.issue(CMD_MPC, 6'h00, `MPC_FIFO_READ);
    check({16'h0, dq_out}, {16'h0, fifo.pop_front()});
    u_ctrl.idle(2);
    check({31'h0, ready_normal}, 32'h1);
    u_ctrl.issue(CMD_ARRAY, 6'h00, 8'h00);
    ahb(`REG_REFUSED, 1'b0, 32'h0);
    check(rd, 32'h1);
    ahb(`REG_STATUS, 1'b0, 32'h0);
    check(rd & 32'h7, {29'h0, PH_NORMAL});
    ahb(`REG_ERROR, 1'b0, 32'h0);
    check(rd, 32'h0);
    ahb(8'h20, 1'b0, 32'h0);
    check(rd, 32'h0);
    check_mrs();
    u_ctrl.cke_down();
    check({15'h0, dq_oe, 13'h0, phase}, {29'h0, PH_RESET});
    u_ctrl.pin_reset(3);
    mr_defaults();
    u_ctrl.cke_up();
    check({28'h0, ready_normal, phase}, {29'h0, PH_BOOT});
    check_mrs();
    // Bypass skips training, then an early latch must be flagged and cleared
    ahb(`REG_CTRL, 1'b1, 32'h1);
    u_ctrl.idle(2);
    check({31'h0, ready_normal}, 32'h1);
    u_ctrl.issue(CMD_ZQ_START, 6'h00, 8'h00);
    u_ctrl.issue(CMD_ZQ_LATCH, 6'h00, 8'h00);
    ahb(`REG_ERROR, 1'b0, 32'h0);
    check(rd, 32'h1 << `ERR_EARLY_LATCH);
    ahb(`REG_ERROR, 1'b1, 32'h1 << `ERR_EARLY_LATCH);
    ahb(`REG_ERROR, 1'b0, 32'h0);
    check(rd, 32'h0);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    print_verdict();
  end
endmodule
